/* verilog/tbs_pkg.sv */
// Shared constants for the thermistor and battery status register bank.
// Assumes an 8-bit register pointer and an I2C-compatible slave in the top.
package tbs_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS2   = 8'h09;  // Charger status, second
    localparam logic [7:0] ADDR_BIAS_CTRL = 8'h0a;  // Thermistor bias control
    localparam logic [7:0] ADDR_HOT       = 8'h0b;  // Hot threshold
    localparam logic [7:0] ADDR_WARM      = 8'h0c;  // Warm threshold
    localparam logic [7:0] ADDR_COOL      = 8'h0d;  // Cool threshold
    localparam logic [7:0] ADDR_COLD      = 8'h0e;  // Cold threshold
    localparam logic [7:0] ADDR_VOLT_LOW  = 8'h0f;  // Node voltage, low byte
    localparam logic [7:0] ADDR_VOLT_HIGH = 8'h10;  // Node voltage, high nibble

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int ZONE_MSB  = 7;   // Temperature zone code
    localparam int ZONE_LSB  = 5;
    localparam int OV_BIT    = 4;   // Overvoltage flag
    localparam int UV_BIT    = 3;   // Undervoltage flag
    localparam int COND_MSB  = 2;   // Battery condition code
    localparam int BSEL_MSB  = 7;   // Bias current select
    localparam int BSEL_LSB  = 6;
    localparam int FORCE_BIT = 0;   // Bias force-on
    localparam int VHI_MSB   = 11;  // Node voltage upper nibble
    localparam int VHI_LSB   = 8;
    localparam int VLO_MSB   = 7;   // Node voltage low byte
    localparam int NIB_MSB   = 3;   // Nibble position in high register

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] HOT_RESET   = 8'h56;
    localparam logic [7:0] WARM_RESET  = 8'h8f;
    localparam logic [7:0] COOL_RESET  = 8'h71;
    localparam logic [7:0] COLD_RESET  = 8'hb4;
    localparam logic       FORCE_RESET = 1'b0;

    // Threshold scaling in microvolts per count, for software use
    localparam int HOT_WARM_UV_PER_LSB = 2000;
    localparam int COOL_COLD_UV_PER_LSB = 10000;

    // ------------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] BSEL_60UA = 2'h0;
    localparam logic [1:0] BSEL_12UA = 2'h1;
    localparam logic [5:0] BIAS_UA_60 = 6'h3c;
    localparam logic [5:0] BIAS_UA_12 = 6'h0c;
    localparam logic [5:0] BIAS_UA_6  = 6'h06;
    localparam logic [2:0] ZONE_OFF  = 3'h0;
    localparam logic [2:0] ZONE_COLD = 3'h1;
    localparam logic [2:0] ZONE_COOL = 3'h2;
    localparam logic [2:0] ZONE_WARM = 3'h3;
    localparam logic [2:0] ZONE_HOT  = 3'h4;
    localparam logic [2:0] ZONE_OK   = 3'h7;
    localparam logic [2:0] CNT_LAST  = 3'h7;  // Last bit of a serial byte

    typedef logic [7:0] tbs_byte_t;

    // Serial engine states, Gray along idle-address-ack-write-read
    typedef enum logic [2:0] {
        TBS_IDLE  = 3'b000,
        TBS_ADDR  = 3'b001,
        TBS_ACK   = 3'b011,
        TBS_WRITE = 3'b010,
        TBS_READ  = 3'b110,
        TBS_RACK  = 3'b111
    } tbs_state_e;

endpackage : tbs_pkg

/* verilog/tbs_pin_sync.sv */
// Three-stage synchroniser with agreement filter for serial bus pins.
// Assumes pins are asynchronous to clk; output moves once stages 2 and 3 agree.
`timescale 1ns/100ps
module tbs_pin_sync #(
    parameter int         WIDTH     = 2,
    parameter logic [1:0] RESET_VAL = 2'h3
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] pinLevel
);

    // ------------------------------------------------------------------
    // Stages
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] stage1;          // Metastable capture, read by stage2 only
    logic [WIDTH-1:0] stage2;          // Second stage
    logic [WIDTH-1:0] stage3;          // Third stage
    logic [WIDTH-1:0] next_pinLevel;   // Filtered level

    // Take the new level only where the two settled stages agree
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            next_pinLevel[i] = (stage2[i] == stage3[i]) ? stage3[i] : pinLevel[i];
        end
    end

    // Register the chain; idle bus lines reset high
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stage1   <= RESET_VAL[WIDTH-1:0];
            stage2   <= RESET_VAL[WIDTH-1:0];
            stage3   <= RESET_VAL[WIDTH-1:0];
            pinLevel <= RESET_VAL[WIDTH-1:0];
        end else begin
            stage1   <= pinIn;
            stage2   <= stage1;
            stage3   <= stage2;
            pinLevel <= next_pinLevel;
        end
    end

endmodule : tbs_pin_sync

/* verilog/tbs_status_regs.sv */
// Thermistor and battery status register bank behind an I2C-compatible slave.
// Assumes status and node voltage inputs come from logic on clk.
// Contract
// [R1] Zone code in status bits 7:5
// [R2] Bit 4 shows overvoltage protection active
// [R3] Bit 3 shows undervoltage protection active
// [R4] Battery condition code in bits 2:0
// [R5] Bias select: 60, 12, 6, 6 microamps
// [R6] Force bit keeps bias on; resets zero
// [R7] Hot threshold register, reset 0x56
// [R8] Warm threshold register, reset 0x8F
// [R9] Cool threshold register, reset 0x71
// [R10] Cold threshold register, reset 0xB4
// [R11] Read-only low byte of node voltage
// [R12] Host divides voltage by bias current
// [R13] Upper node voltage nibble in next register
// [R14] Read-only writes ignored, reserved read zero
`timescale 1ns/100ps
module tbs_status_regs
    import tbs_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR   = 7'h2a,  // Arbitrary bus address
    parameter logic [1:0] BSEL_RESET = 2'h0    // Power-up bias select
) (
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              sclIn,
    input  wire logic              sdaIn,
    output logic                   sdaOut,
    output logic                   sdaOe,
    input  wire logic [2:0]        tempZoneCode,
    input  wire logic              overvoltageFlag,
    input  wire logic              undervoltageFlag,
    input  wire logic [2:0]        batteryConditionCode,
    input  wire logic [11:0]       nodeVoltage,
    input  wire logic              inputSupplyOk,
    output logic [1:0]             biasCurrentSelect,
    output logic [5:0]             biasCurrentUa,
    output logic                   biasForceOn,
    output logic                   biasSourceOn,
    output tbs_pkg::tbs_byte_t     hotThreshold,
    output tbs_pkg::tbs_byte_t     warmThreshold,
    output tbs_pkg::tbs_byte_t     coolThreshold,
    output tbs_pkg::tbs_byte_t     coldThreshold
);
    import tbs_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [1:0]  pinLevel;                     // Filtered {scl, sda}
    logic        sclS, sdaS;                   // Filtered pin levels
    logic        sclPrev, next_sclPrev;        // Edge detection history
    logic        sdaPrev, next_sdaPrev;
    tbs_state_e  state, next_state;            // Serial engine state
    logic [2:0]  bitCnt, next_bitCnt;          // Bit within byte
    logic        gotByte, next_gotByte;        // Eight bits received or sent
    logic [7:0]  rxShift, next_rxShift;        // Incoming byte
    logic [7:0]  txShift, next_txShift;        // Outgoing byte
    logic [7:0]  ptr, next_ptr;                // Register pointer
    logic        ptrPhase, next_ptrPhase;      // Next write byte is the pointer
    logic        isRead, next_isRead;          // Transfer direction
    logic        masterAck, next_masterAck;    // Master acked last read byte
    logic        sdaDrive, next_sdaDrive;      // Pull the data line low
    logic [1:0]  next_biasCurrentSelect;
    logic [5:0]  next_biasCurrentUa;
    logic        next_biasForceOn;
    logic        next_biasSourceOn;
    tbs_byte_t   next_hot, next_warm, next_cool, next_cold;
    logic        sclRise, sclFall;             // Clock edges
    logic        startSeen, stopSeen;          // Bus conditions
    logic        loadTx;                       // Fetch a byte for reading
    logic        wrCommit;                     // Store a written byte
    tbs_byte_t   txByte;                       // Fetched byte

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Bias current in microamps for a select code
    function automatic logic [5:0] biasUa(input logic [1:0] sel);
        logic [5:0] ua;
        ua = BIAS_UA_6;
        if (sel == BSEL_60UA) begin
            ua = BIAS_UA_60;
        end else if (sel == BSEL_12UA) begin
            ua = BIAS_UA_12;
        end
        return ua;
    endfunction : biasUa

    // Read data for a pointer; reserved bits and unmapped offsets give zero
    function automatic tbs_byte_t readMux(input logic [7:0] a);
        tbs_byte_t r;
        r = 8'h00;
        case (a)
            ADDR_STATUS2: begin
                r[ZONE_MSB:ZONE_LSB] = tempZoneCode;          // R1
                r[OV_BIT]            = overvoltageFlag;       // R2
                r[UV_BIT]            = undervoltageFlag;      // R3
                r[COND_MSB:0]        = batteryConditionCode;  // R4
            end
            ADDR_BIAS_CTRL: begin
                r[BSEL_MSB:BSEL_LSB] = biasCurrentSelect;
                r[FORCE_BIT]         = biasForceOn;           // R14
            end
            ADDR_HOT:       r = hotThreshold;
            ADDR_WARM:      r = warmThreshold;
            ADDR_COOL:      r = coolThreshold;
            ADDR_COLD:      r = coldThreshold;
            ADDR_VOLT_LOW:  r = nodeVoltage[VLO_MSB:0];       // R11
            ADDR_VOLT_HIGH: r[NIB_MSB:0] = nodeVoltage[VHI_MSB:VHI_LSB];  // R13
            default:        r = 8'h00;
        endcase
        return r;
    endfunction : readMux

    // ------------------------------------------------------------------
    // Pin input
    // ------------------------------------------------------------------
    tbs_pin_sync #(
        .WIDTH     (2),
        .RESET_VAL (2'h3)
    ) u_pin_sync (
        .clk      (clk),
        .nrst     (nrst),
        .pinIn    ({sclIn, sdaIn}),
        .pinLevel (pinLevel)
    );

    assign sclS      = pinLevel[1];
    assign sdaS      = pinLevel[0];
    assign sclRise   = sclS && !sclPrev;
    assign sclFall   = !sclS && sclPrev;
    assign startSeen = sclS && sclPrev && sdaPrev && !sdaS;
    assign stopSeen  = sclS && sclPrev && !sdaPrev && sdaS;
    assign sdaOut    = 1'b0;      // Open drain: only ever pulls low
    assign sdaOe     = sdaDrive;

    // ------------------------------------------------------------------
    // Next-state logic for serial engine and registers
    // ------------------------------------------------------------------
    // No clock stretching, so every byte is fetched at a single scl fall
    always_comb begin
        next_sclPrev = sclS;
        next_sdaPrev = sdaS;
        next_state = state;
        next_bitCnt = bitCnt;
        next_gotByte = gotByte;
        next_rxShift = rxShift;
        next_txShift = txShift;
        next_ptr = ptr;
        next_ptrPhase = ptrPhase;
        next_isRead = isRead;
        next_masterAck = masterAck;
        next_sdaDrive = sdaDrive;
        next_biasCurrentSelect = biasCurrentSelect;
        next_biasForceOn = biasForceOn;
        next_hot = hotThreshold;
        next_warm = warmThreshold;
        next_cool = coolThreshold;
        next_cold = coldThreshold;
        loadTx = 1'b0;
        wrCommit = 1'b0;
        txByte = readMux(ptr);
        // Sample data on the rising clock
        if (sclRise) begin
            if (state == TBS_ADDR || state == TBS_WRITE || state == TBS_READ) begin
                next_rxShift = {rxShift[6:0], sdaS};
                next_bitCnt  = bitCnt + 3'h1;
                if (bitCnt == CNT_LAST) begin
                    next_gotByte = 1'b1;
                end
            end
            if (state == TBS_RACK) begin
                next_masterAck = !sdaS;
            end
        end
        // Change the data line on the falling clock
        if (sclFall) begin
            case (state)
                TBS_ADDR: begin
                    if (gotByte) begin
                        next_gotByte = 1'b0;
                        if (rxShift[7:1] == DEV_ADDR) begin
                            next_isRead   = rxShift[0];
                            next_sdaDrive = 1'b1;
                            next_state    = TBS_ACK;
                        end else begin
                            next_state = TBS_IDLE;   // Not ours: wait for a start
                        end
                    end
                end
                TBS_WRITE: begin
                    if (gotByte) begin
                        next_gotByte  = 1'b0;
                        next_sdaDrive = 1'b1;
                        next_state    = TBS_ACK;
                        if (ptrPhase) begin
                            next_ptr      = rxShift;
                            next_ptrPhase = 1'b0;
                        end else begin
                            wrCommit = 1'b1;
                            next_ptr = ptr + 8'h01;
                        end
                    end
                end
                TBS_ACK: begin
                    if (isRead) begin
                        loadTx = 1'b1;
                    end else begin
                        next_sdaDrive = 1'b0;
                        next_state    = TBS_WRITE;
                    end
                end
                TBS_READ: begin
                    if (gotByte) begin
                        next_gotByte  = 1'b0;
                        next_sdaDrive = 1'b0;
                        next_state    = TBS_RACK;
                    end else begin
                        next_txShift  = {txShift[6:0], 1'b0};
                        next_sdaDrive = !txShift[6];
                    end
                end
                TBS_RACK: begin
                    next_sdaDrive = 1'b0;
                    if (masterAck) begin
                        loadTx = 1'b1;
                    end else begin
                        next_state = TBS_IDLE;   // Master ended the read
                    end
                end
                default: begin
                end
            endcase
        end
        // Fetch a byte and put its first bit on the line
        if (loadTx) begin
            next_txShift  = txByte;
            next_ptr      = ptr + 8'h01;
            next_sdaDrive = !txByte[7];
            next_state    = TBS_READ;
        end
        // Store written data; read-only and unmapped offsets drop it
        if (wrCommit) begin
            case (ptr)
                ADDR_BIAS_CTRL: begin
                    next_biasCurrentSelect = rxShift[BSEL_MSB:BSEL_LSB];
                    next_biasForceOn       = rxShift[FORCE_BIT];   // R6
                end
                ADDR_HOT:  next_hot  = rxShift;                    // R7
                ADDR_WARM: next_warm = rxShift;                    // R8
                ADDR_COOL: next_cool = rxShift;                    // R9
                ADDR_COLD: next_cold = rxShift;                    // R10
                default: begin                                     // R14
                end
            endcase
        end
        // Bus conditions override everything else
        if (startSeen) begin
            next_state    = TBS_ADDR;
            next_bitCnt   = 3'h0;
            next_gotByte  = 1'b0;
            next_ptrPhase = 1'b1;
            next_sdaDrive = 1'b0;
        end else if (stopSeen) begin
            next_state    = TBS_IDLE;
            next_sdaDrive = 1'b0;
        end
        next_biasCurrentUa = biasUa(next_biasCurrentSelect);       // R5
        next_biasSourceOn  = biasForceOn || inputSupplyOk;         // R6
    end

    // Register everything; thresholds reset to their documented defaults
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
            state <= TBS_IDLE;
            bitCnt <= 3'h0;
            gotByte <= 1'b0;
            rxShift <= 8'h00;
            txShift <= 8'h00;
            ptr <= 8'h00;
            ptrPhase <= 1'b1;
            isRead <= 1'b0;
            masterAck <= 1'b0;
            sdaDrive <= 1'b0;
            biasCurrentSelect <= BSEL_RESET;
            biasCurrentUa <= BIAS_UA_60;
            biasForceOn <= FORCE_RESET;
            biasSourceOn <= 1'b0;
            hotThreshold <= HOT_RESET;
            warmThreshold <= WARM_RESET;
            coolThreshold <= COOL_RESET;
            coldThreshold <= COLD_RESET;
        end else begin
            sclPrev <= next_sclPrev;
            sdaPrev <= next_sdaPrev;
            state <= next_state;
            bitCnt <= next_bitCnt;
            gotByte <= next_gotByte;
            rxShift <= next_rxShift;
            txShift <= next_txShift;
            ptr <= next_ptr;
            ptrPhase <= next_ptrPhase;
            isRead <= next_isRead;
            masterAck <= next_masterAck;
            sdaDrive <= next_sdaDrive;
            biasCurrentSelect <= next_biasCurrentSelect;
            biasCurrentUa <= next_biasCurrentUa;
            biasForceOn <= next_biasForceOn;
            biasSourceOn <= next_biasSourceOn;
            hotThreshold <= next_hot;
            warmThreshold <= next_warm;
            coolThreshold <= next_cool;
            coldThreshold <= next_cold;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_load(logic [7:0] a);
        loadTx && (ptr == a);
    endsequence
    sequence s_commit(logic [7:0] a);
        wrCommit && (ptr == a);
    endsequence

    property p_zone;      s_load(ADDR_STATUS2) |=> txShift[7:5] == $past(tempZoneCode); endproperty
    a_zone: assert property (p_zone) else $error("zone field wrong"); // R1
    property p_ov;        s_load(ADDR_STATUS2) |=> txShift[4] == $past(overvoltageFlag); endproperty
    a_ov: assert property (p_ov) else $error("overvoltage bit wrong"); // R2
    property p_uv;        s_load(ADDR_STATUS2) |=> txShift[3] == $past(undervoltageFlag); endproperty
    a_uv: assert property (p_uv) else $error("undervoltage bit wrong"); // R3
    property p_cond;      s_load(ADDR_STATUS2) |=> txShift[2:0] == $past(batteryConditionCode); endproperty
    a_cond: assert property (p_cond) else $error("battery condition wrong"); // R4
    property p_bias;
        ##1 (biasCurrentUa == ((biasCurrentSelect == BSEL_60UA) ? BIAS_UA_60 :
                               (biasCurrentSelect == BSEL_12UA) ? BIAS_UA_12 : BIAS_UA_6));
    endproperty
    a_bias: assert property (p_bias) else $error("bias current decode wrong"); // R5
    property p_force;     (biasForceOn && !inputSupplyOk) ##1 biasForceOn |-> biasSourceOn; endproperty
    a_force: assert property (p_force) else $error("bias source off while forced"); // R6
    property p_hot;       s_commit(ADDR_HOT) |=> hotThreshold == $past(rxShift); endproperty
    a_hot: assert property (p_hot) else $error("hot threshold not stored"); // R7
    property p_warm;      s_commit(ADDR_WARM) |=> warmThreshold == $past(rxShift); endproperty
    a_warm: assert property (p_warm) else $error("warm threshold not stored"); // R8
    property p_cool;      s_commit(ADDR_COOL) |=> coolThreshold == $past(rxShift); endproperty
    a_cool: assert property (p_cool) else $error("cool threshold not stored"); // R9
    property p_cold;      s_commit(ADDR_COLD) |=> coldThreshold == $past(rxShift); endproperty
    a_cold: assert property (p_cold) else $error("cold threshold not stored"); // R10
    property p_vlow;      s_load(ADDR_VOLT_LOW) |=> txShift == $past(nodeVoltage[7:0]); endproperty
    a_vlow: assert property (p_vlow) else $error("voltage low byte wrong"); // R11
    property p_vhigh;     s_load(ADDR_VOLT_HIGH) |=> txShift == {4'h0, $past(nodeVoltage[11:8])}; endproperty
    a_vhigh: assert property (p_vhigh) else $error("voltage high nibble wrong"); // R13
    property p_ro;
        s_commit(ADDR_STATUS2) or s_commit(ADDR_VOLT_LOW) or s_commit(ADDR_VOLT_HIGH) |=>
            $stable(hotThreshold) && $stable(warmThreshold) && $stable(coolThreshold) &&
            $stable(coldThreshold) && $stable(biasCurrentSelect) && $stable(biasForceOn);
    endproperty
    a_ro: assert property (p_ro) else $error("read-only write changed state"); // R14
    property p_resv;      s_load(ADDR_BIAS_CTRL) |=> txShift[5:1] == 5'h00; endproperty
    a_resv: assert property (p_resv) else $error("reserved bits not zero"); // R14

endmodule : tbs_status_regs

/* testbench/tbs_host_model.sv */
// Host model: I2C master that reads and writes the register bank.
// Assumes SDA is resolved open drain with a pull-up; bus address 0x2a.
`timescale 1ns/100ps
module tbs_host_model (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sdaPull
);
    logic [7:0] prevByte;  // Read byte before the last one of a burst
    initial {scl, sdaPull} = 2'b10;
    // One bus phase; both lines change just after a clock edge
    task automatic ph(input logic p, input logic c);
        sdaPull <= p;
        scl     <= c;
        repeat (10) @(posedge clk);  // Above the 8 clk minimum
    endtask : ph
    // Nine bits MSB first; bit 0 is the ACK slot, sampled while SCL is high
    task automatic byte_x(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            ph(~d[i], 1'b0);
            ph(~d[i], 1'b1);
            q[i] = sda;
            ph(~d[i], 1'b0);
        end
    endtask : byte_x
    // SDA moves with SCL low except in START and STOP; cnt 0 reads one byte, -1 reads two
    task automatic acc(input logic [7:0] a, input logic [7:0] d, input int cnt, output logic [8:0] q);
        for (int k = 0; k < 4; k++) ph(k > 1, k inside {1, 2});
        byte_x(9'h0a9, q);
        byte_x({a, 1'b1}, q);
        for (int i = 0; i < cnt; i++) byte_x({8'(d + i), 1'b1}, q);
        for (int k = 0; k < 4 * (cnt <= 0); k++) ph(k > 1, k inside {1, 2});
        for (int k = 0; k < (cnt <= 0) * (2 - cnt); k++) begin
            prevByte = q[8:1];
            byte_x(k == 0 ? 9'h0ab : k == 1 - cnt ? 9'h1ff : 9'h1fe, q);
        end
        for (int k = 0; k < 3; k++) ph(k < 2, k > 0);
    endtask : acc
endmodule : tbs_host_model

/* testbench/tb.sv */
// Bench: register bank reached through the host model, status inputs live.
// Assumes default bus address, bias select reset 00, node voltage 0xabc.
`timescale 1ns/100ps
module tb;
    import tbs_pkg::*;
    logic       clk = 1'b0, nrst = 1'b0, ov = 1'b0, uv = 1'b0;
    logic       scl, sdaPull, sdaOe, sdaDo, fOn, srcOn, supOk = 1'b0;
    logic [1:0] bsel;
    wire [31:0] thermistor_pin;  // Cold, cool, warm, hot thresholds, high byte first
    logic [2:0] zone = 3'h0, cond = 3'h0;
    logic [5:0] ua;
    logic [8:0] q;
    int         n_mismatch = 0, total_checks = 0, cycles = 0;
    wire        sda = ~((sdaOe & ~sdaDo) | sdaPull);  // Released wire reads high
    tbs_host_model host (.clk(clk), .sda(sda), .scl(scl), .sdaPull(sdaPull));
    tbs_status_regs uut (.clk(clk), .nrst(nrst), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaDo), .sdaOe(sdaOe),
        .tempZoneCode(zone), .overvoltageFlag(ov), .undervoltageFlag(uv), .batteryConditionCode(cond),
        .nodeVoltage(12'habc), .inputSupplyOk(supOk), .biasCurrentUa(ua), .biasForceOn(fOn), .biasSourceOn(srcOn),
        .biasCurrentSelect(bsel), .hotThreshold(thermistor_pin[7:0]), .warmThreshold(thermistor_pin[15:8]),
        .coolThreshold(thermistor_pin[23:16]), .coldThreshold(thermistor_pin[31:24]));
    always #5 clk = ~clk;
    always @(posedge clk) if (++cycles == 90000) print_verdict;  // Hang guard, nearly three times the traffic
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) n_mismatch++;
        if (got !== exp) $display("Error at %0t: read %h, expected %h", $time, got, exp);
    endtask : chk
    task automatic print_verdict;
        if (cycles >= 90000) n_mismatch++;
        if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : print_verdict
    // Reset values, a six-byte burst onto the read-only voltage bytes, then a paired voltage read
    task automatic t_regs;
        logic [7:0] rv [5] = '{8'h00, HOT_RESET, WARM_RESET, COOL_RESET, COLD_RESET};
        for (int i = 0; i < 5; i++) begin
            host.acc(8'(ADDR_BIAS_CTRL + i), 8'h00, 0, q);
            chk(q[8:1], rv[i]);
            if (i > 0) chk(thermistor_pin[8 * (i - 1) +: 8], rv[i]);
        end
        host.acc(ADDR_HOT, 8'h5a, 6, q);
        for (int i = 0; i < 6; i++) begin
            host.acc(8'(ADDR_HOT + i), 8'h00, 0, q);
            chk(q[8:1], i < 4 ? 8'(8'h5a + i) : i == 4 ? 8'hbc : 8'h0a);
            if (i < 4) chk(thermistor_pin[8 * i +: 8], 8'(8'h5a + i));
        end
        // Burst read of both voltage bytes, divided by the 60 uA bias: 2748 mV / 60 gives 45 kohm
        host.acc(ADDR_VOLT_LOW, 8'h00, -1, q);
        chk(8'({q[4:1], host.prevByte} / ua), 8'h2d);
    endtask : t_regs
    // Each select code, reserved bits written high, force and supply toggled
    task automatic t_bias;
        for (int s = 0; s < 4; s++) begin
            supOk <= s[1];
            host.acc(ADDR_BIAS_CTRL, {2'(s), 5'h1f, s[0]}, 1, q);
            chk({ua, fOn, srcOn}, {s == 0 ? BIAS_UA_60 : s == 1 ? BIAS_UA_12 : BIAS_UA_6, s[0], s[0] | s[1]});
            chk({6'h00, bsel}, 8'(s));
            host.acc(ADDR_BIAS_CTRL, 8'h00, 0, q);
            chk(q[8:1], {2'(s), 5'h00, s[0]});
        end
    endtask : t_bias
    // Zone, protection flags and condition codes follow their inputs
    task automatic t_status;
        logic [7:0] e;
        for (int i = 0; i < 6; i++) begin
            e = {3'(i == 5 ? 7 : i), i[0], i[1], 3'(i % 5)};
            {zone, ov, uv, cond} <= e;
            host.acc(ADDR_STATUS2, 8'h00, 0, q);
            chk(q[8:1], e);
        end
    endtask : t_status
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        t_regs;
        t_bias;
        t_status;
        print_verdict;
    end
endmodule : tb
